// *** src/acs_top.sv ***
// Converter sequencer with AHB-Lite register slave
//
// Added by the designer: the address map and register access over AHB-Lite.
`include "acs_defines.svh"
`default_nettype none
module acs_top (
   // Clock and reset
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   // AHB-Lite slave
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic      [31:0]                 hrdata,
   output logic                             hreadyout,
   output logic                             hresp,
   // Trigger sources
   input  wire logic                        external_trigger_in_n,
   input  wire logic                        timer_underflow,
   // Analog core
   output var acs_pkg::acs_analog_req_type  analog_req,
   input  wire logic [9:0]                  analog_result,
   // Shared interrupt request
   output logic                             converter_irq
);

   acs_pkg::acs_state_type state_reg;
   acs_pkg::acs_state_type state_next;

   // Register map, one word each, data in the low half
   // Result word: justified 10-bit sample, read-only
   // Result word: any read of it clears the completion flag
   // Trigger word: [13:11] last channel, [10:8] first channel
   // Trigger word: 7 justify (1 left), 6 mode (1 continuous)
   // Trigger word: [5:4] source, [2:0] sampling select
   // Control word: 0 enable, 1 run and software start
   // Control word: 2 completion request enable, 3 overwrite request enable
   // Control word: 4 completion flag, read-only
   // Control word: 5 overwrite flag, write one clears
   // Control word: [10:8] channel in flight, read-only
   // Clock word: [3:0] divider code, top code treated as the slowest
   // Upper halves and unmapped words read zero and ignore writes
   // Misaligned or out-of-range addresses count as unmapped
   // Writes land at the end of the data phase with no wait state
   // Reads spend one wait state so read data leaves a flop
   // Size is ignored: every access is taken as a whole word
   // Settings are plain stores with no interlock against a running scan,
   // So changing them while enabled can confuse the sequencer

   // Decoded bus request
   logic        addr_take;
   logic        sel_ok;
   logic [1:0]  sel_idx;
   logic [15:0] word_idx;
   // Sequencer helpers
   logic        adclk_tick;
   logic [14:0] div_limit;
   logic [3:0]  cdiv_eff;
   logic [3:0]  samp_last;
   logic        trig_hit;
   logic        chan_done;
   logic [15:0] placed;
   logic [31:0] wdata;
   logic        wr_trig;
   logic        wr_ctrl;
   logic        wr_clock;
   logic        rd_result;

   assign addr_take = hsel & hready & htrans[1];
   assign word_idx  = haddr[17:2];

   // Address decode; upper bits must be clear
   // Only the word index matters once alignment and range are checked
   // Unmapped words keep sel_ok low, so they read zero and drop writes
   always_comb begin
      sel_ok  = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
      sel_idx = 2'h0;
      case (word_idx)
         `ACS_IDX_RESULT: sel_idx = 2'h0;
         `ACS_IDX_TRIG:   sel_idx = 2'h1;
         `ACS_IDX_CTRL:   sel_idx = 2'h2;
         `ACS_IDX_CLOCK:  sel_idx = 2'h3;
         default:         sel_ok  = 1'b0;
      endcase
   end

   // Bus outputs; reads take one wait state so hrdata comes from a flop
   assign hrdata    = state_reg.rdata;
   assign hreadyout = ~state_reg.rd_pend;
   assign hresp     = 1'b0;

   // Analog core request follows the sequencer phase
   // Decoded from the phase flop, so the core never sees a glitchy mix
   // Channel holds still for a whole sample-and-convert pair
   assign analog_req.sample  = (state_reg.phase == acs_pkg::ACS_SAMPLE);
   assign analog_req.convert = (state_reg.phase == acs_pkg::ACS_CONVERT);
   assign analog_req.channel = state_reg.chan;

   // one shared request
   // Level request; software clears the flag to drop it
   assign converter_irq = (state_reg.cf & state_reg.cie) | (state_reg.owe & state_reg.oie);

   // reserved code runs as the slowest ratio
   always_comb begin
      cdiv_eff = state_reg.cdiv;
      if (state_reg.cdiv > `ACS_CDIV_MAX) begin
         cdiv_eff = `ACS_CDIV_MAX;
      end
   end

   // power-of-two divide
   // At the top ratio the shift wraps to zero and the limit becomes all ones
   always_comb begin
      div_limit  = (15'h0002 << cdiv_eff) - 15'h0001;
      adclk_tick = (state_reg.div_cnt >= div_limit);
   end

   // Data-phase write strobes
   always_comb begin
      wdata     = hwdata;
      wr_trig   = state_reg.wr_pend & state_reg.rsel_ok & (state_reg.rsel == 2'h1);
      wr_ctrl   = state_reg.wr_pend & state_reg.rsel_ok & (state_reg.rsel == 2'h2);
      wr_clock  = state_reg.wr_pend & state_reg.rsel_ok & (state_reg.rsel == 2'h3);
      rd_result = state_reg.rd_pend & state_reg.rsel_ok & (state_reg.rsel == 2'h0);
   end

   always_comb begin
      case (state_reg.tsel)
         `ACS_TSEL_EXT:   trig_hit = state_reg.trig_prev & ~external_trigger_in_n;
         `ACS_TSEL_TIMER: trig_hit = timer_underflow;
         `ACS_TSEL_SOFT:  trig_hit = wr_ctrl & wdata[`ACS_CTL_RUN];
         default:         trig_hit = 1'b0;
      endcase
   end

   assign samp_last = {1'b0, state_reg.samp} + `ACS_SAMP_EXTRA - 4'h1;
   assign chan_done = adclk_tick & (state_reg.phase == acs_pkg::ACS_CONVERT)
                      & (state_reg.tick_cnt == `ACS_CONV_CYCLES - 4'h1);

   // justification with zero fill
   // Six pad bits either side keep the sample in one half-word
   assign placed = state_reg.justify ? {analog_result, {`ACS_JUSTIFY_PAD{1'b0}}}
                                     : {{`ACS_JUSTIFY_PAD{1'b0}}, analog_result};

   // Next-state logic
   always_comb begin
      state_next           = state_reg;
      state_next.trig_prev = external_trigger_in_n;
      state_next.div_cnt   = adclk_tick ? 15'h0000 : state_reg.div_cnt + 15'h0001;

      // Bus phase bookkeeping
      // Address phase is remembered for exactly one data-phase cycle
      // Writes use hwdata in that cycle, reads fill rdata in it
      state_next.wr_pend = addr_take & hwrite;
      state_next.rd_pend = addr_take & ~hwrite;
      if (addr_take) begin
         state_next.rsel    = sel_idx;
         state_next.rsel_ok = sel_ok;
      end

      // Read data captured in the wait state
      if (state_reg.rd_pend) begin
         state_next.rdata = 32'h0000_0000;
         if (state_reg.rsel_ok) begin
            case (state_reg.rsel)
               // Result word
               2'h0: state_next.rdata = {16'h0000, state_reg.result};
               // Trigger and channel word
               2'h1: begin
                  state_next.rdata[`ACS_TRG_LAST_HI:`ACS_TRG_LAST_LO]   = state_reg.last;
                  state_next.rdata[`ACS_TRG_FIRST_HI:`ACS_TRG_FIRST_LO] = state_reg.first;
                  state_next.rdata[`ACS_TRG_JUSTIFY]                    = state_reg.justify;
                  state_next.rdata[`ACS_TRG_MODE]                       = state_reg.mode;
                  state_next.rdata[`ACS_TRG_TSEL_HI:`ACS_TRG_TSEL_LO]   = state_reg.tsel;
                  state_next.rdata[`ACS_TRG_SAMP_HI:`ACS_TRG_SAMP_LO]   = state_reg.samp;
               end
               // Control and status word
               2'h2: begin
                  state_next.rdata[`ACS_CTL_ENABLE]              = state_reg.enable;
                  state_next.rdata[`ACS_CTL_RUN]                 = state_reg.run;
                  state_next.rdata[`ACS_CTL_CH_HI:`ACS_CTL_CH_LO] = state_reg.chan;
                  state_next.rdata[`ACS_CTL_CIE]                 = state_reg.cie;
                  state_next.rdata[`ACS_CTL_OIE]                 = state_reg.oie;
                  state_next.rdata[`ACS_CTL_CF]                  = state_reg.cf;
                  state_next.rdata[`ACS_CTL_OWE]                 = state_reg.owe;
               end
               // Clock word
               2'h3: state_next.rdata[`ACS_CLK_DIV_HI:`ACS_CLK_DIV_LO] = state_reg.cdiv;
               default: state_next.rdata = 32'h0000_0000;
            endcase
         end
      end

      // settings are plain stores; software keeps them still while enabled
      if (wr_trig) begin
         state_next.last    = wdata[`ACS_TRG_LAST_HI:`ACS_TRG_LAST_LO];
         state_next.first   = wdata[`ACS_TRG_FIRST_HI:`ACS_TRG_FIRST_LO];
         state_next.justify = wdata[`ACS_TRG_JUSTIFY];
         state_next.mode    = wdata[`ACS_TRG_MODE];
         state_next.tsel    = wdata[`ACS_TRG_TSEL_HI:`ACS_TRG_TSEL_LO];
         state_next.samp    = wdata[`ACS_TRG_SAMP_HI:`ACS_TRG_SAMP_LO];
      end
      // Divider code stored as written, reserved code included
      if (wr_clock) begin
         state_next.cdiv = wdata[`ACS_CLK_DIV_HI:`ACS_CLK_DIV_LO];
      end
      // Run bit is not stored here; the sequencer owns it
      if (wr_ctrl) begin
         state_next.enable = wdata[`ACS_CTL_ENABLE];
         state_next.cie    = wdata[`ACS_CTL_CIE];
         state_next.oie    = wdata[`ACS_CTL_OIE];
         if (wdata[`ACS_CTL_OWE]) begin
            state_next.owe = 1'b0;
         end
      end
      if (rd_result) begin
         state_next.cf = 1'b0;
      end

      // Sequencer, counted in converter clock ticks
      // Sampling holds the channel for the select value plus two ticks
      // Conversion follows for eleven ticks, then the result is stored
      // The next channel starts sampling on the very next cycle
      // One-time scans stop after the last channel
      // Continuous scans go back to the first channel without a gap
      // Channel steps are 3-bit, so a last below first wraps through 7
      // Triggers are only looked at while idle, so a late pulse
      // Never restarts or stretches a scan in flight
      // The divider runs free, so the first tick lands one to 2<<code
      // Cycles after the trigger; scan length jitters by that much
      case (state_reg.phase)
         acs_pkg::ACS_IDLE: begin
            state_next.tick_cnt = 4'h0;
            if (state_reg.enable & trig_hit) begin
               state_next.phase = acs_pkg::ACS_SAMPLE;
               state_next.chan  = state_reg.first;
               state_next.run   = 1'b1;
            end
         end
         acs_pkg::ACS_SAMPLE: begin
            if (adclk_tick) begin
               if (state_reg.tick_cnt == samp_last) begin
                  state_next.phase    = acs_pkg::ACS_CONVERT;
                  state_next.tick_cnt = 4'h0;
               end else begin
                  state_next.tick_cnt = state_reg.tick_cnt + 4'h1;
               end
            end
         end
         acs_pkg::ACS_CONVERT: begin
            if (adclk_tick) begin
               state_next.tick_cnt = state_reg.tick_cnt + 4'h1;
            end
            if (chan_done) begin
               state_next.result   = placed;
               state_next.cf       = 1'b1;
               state_next.tick_cnt = 4'h0;
               // overwrite sets the error; set wins over clear
               // A result read in this same cycle still counts as too late
               if (state_reg.cf) begin
                  state_next.owe = 1'b1;
               end
               if (state_reg.chan == state_reg.last) begin
                  if (state_reg.mode) begin
                     state_next.phase = acs_pkg::ACS_SAMPLE;
                     state_next.chan  = state_reg.first;
                  end else begin
                     // single pass, run cleared at end
                     state_next.phase = acs_pkg::ACS_IDLE;
                     state_next.run   = 1'b0;
                  end
               end else begin
                  // 3-bit step wraps 7 to 0
                  state_next.phase = acs_pkg::ACS_SAMPLE;
                  state_next.chan  = state_reg.chan + 3'h1;
               end
            end
         end
         default: begin
            state_next.phase = acs_pkg::ACS_IDLE;
            state_next.run   = 1'b0;
         end
      endcase

      // forced stop discards the channel in flight
      // Dropping enable mid-scan stops the same way in either mode
      // Flags keep their bus updates but gain nothing from the lost channel
      if (state_reg.phase != acs_pkg::ACS_IDLE) begin
         if ((wr_ctrl & state_reg.mode & ~wdata[`ACS_CTL_RUN]) | ~state_reg.enable) begin
            state_next.phase    = acs_pkg::ACS_IDLE;
            state_next.run      = 1'b0;
            state_next.tick_cnt = 4'h0;
            state_next.result   = state_reg.result;
            state_next.cf       = rd_result ? 1'b0 : state_reg.cf;
            state_next.owe      = (wr_ctrl & wdata[`ACS_CTL_OWE]) ? 1'b0 : state_reg.owe;
         end
      end
   end

   // State register
   // Trigger history resets high so an idle pin gives no false edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg           <= '0;
         state_reg.phase     <= acs_pkg::ACS_IDLE;
         state_reg.trig_prev <= 1'b1;
         state_reg.samp      <= `ACS_SAMP_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

endmodule
`default_nettype wire

// *** src/acs_defines.svh ***
// Constants for the converter sequencer: register indices, fields, resets, counts
// Behaviour
// - Mode bit 0 (reset default): scan start to end channel once, then stop.
// - Mode bit 1: repeat the channel scan until software stops it.
// - Trigger select: 3 external pin, 1 timer underflow, 0 software, 2 reserved.
// - External source: a falling edge on the trigger input starts a sequence.
// - Timer source: each timer underflow pulse starts a sequence.
// - Software source: writing 1 to the run/status bit starts a sequence.
// - Sampling lasts field value plus two converter clocks; reset value 7.
// - Each channel takes sampling cycles plus 11 converter clocks.
// - Result justified left (bits 15..6) or right (bits 9..0); others zero.
// - Triggers act only while the converter enable bit is 1.
// - Only the selected trigger source is heeded; others are ignored.
// - Accepted trigger starts at start channel, steps up to the end channel.
// - Run/status reads 1 while busy; indicator shows the active channel.
// - Each finished channel writes the result and sets the completion flag.
// - Reading the result register clears the completion flag.
// - Finishing while completion flag set: overwrite, set overwrite and completion.
// - Overwrite flag clears only by writing 1; writing 0 leaves it.
// - Overwrite error never halts or pauses continuous scanning.
// - One-time mode clears run/status when the end channel completes.
// - Continuous mode: writing 0 to run/status aborts; current result discarded.
// - End below start: sequence wraps from channel 7 to 0 onward to end.
// - Converter clock is peripheral clock over 2 to 32768 by field 0..14.
// - Completion and overwrite, each gated by its enable, drive one request.
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// Register indices; byte address is four times the index
`define ACS_IDX_RESULT   16'h5380
`define ACS_IDX_TRIG     16'h5382
`define ACS_IDX_CTRL     16'h5384
`define ACS_IDX_CLOCK    16'h5386

// Trigger/channel register fields
`define ACS_TRG_LAST_HI  13
`define ACS_TRG_LAST_LO  11
`define ACS_TRG_FIRST_HI 10
`define ACS_TRG_FIRST_LO 8
`define ACS_TRG_JUSTIFY  7
`define ACS_TRG_MODE     6
`define ACS_TRG_TSEL_HI  5
`define ACS_TRG_TSEL_LO  4
`define ACS_TRG_SAMP_HI  2
`define ACS_TRG_SAMP_LO  0

// Control/status register fields
`define ACS_CTL_ENABLE   0
`define ACS_CTL_RUN      1
`define ACS_CTL_CIE      2
`define ACS_CTL_OIE      3
`define ACS_CTL_CF       4
`define ACS_CTL_OWE      5
`define ACS_CTL_CH_HI    10
`define ACS_CTL_CH_LO    8

// Clock register field
`define ACS_CLK_DIV_HI   3
`define ACS_CLK_DIV_LO   0

// Trigger source codes
`define ACS_TSEL_SOFT    2'h0
`define ACS_TSEL_TIMER   2'h1
`define ACS_TSEL_EXT     2'h3

// Reset values and timing counts
`define ACS_SAMP_RESET   3'h7
`define ACS_SAMP_EXTRA   4'h2
`define ACS_CONV_CYCLES  4'hB
`define ACS_CDIV_MAX     4'hE
`define ACS_JUSTIFY_PAD  6

`endif

// *** src/acs_pkg.sv ***
// Types shared by the converter sequencer and its bench
`default_nettype none
package acs_pkg;

   // Sequencer phase
   typedef enum logic [1:0] {
      ACS_IDLE,
      ACS_SAMPLE,
      ACS_CONVERT
   } acs_phase_type;

   // Request toward the analog core
   typedef struct packed {
      logic       sample;
      logic       convert;
      logic [2:0] channel;
   } acs_analog_req_type;

   // Whole state of the sequencer
   typedef struct packed {
      acs_phase_type phase;
      logic [2:0]    chan;
      logic [3:0]    tick_cnt;
      logic [14:0]   div_cnt;
      logic          trig_prev;
      logic [15:0]   result;
      logic          enable;
      logic          run;
      logic          cie;
      logic          oie;
      logic          cf;
      logic          owe;
      logic [2:0]    first;
      logic [2:0]    last;
      logic          justify;
      logic          mode;
      logic [1:0]    tsel;
      logic [2:0]    samp;
      logic [3:0]    cdiv;
      logic          wr_pend;
      logic          rd_pend;
      logic [1:0]    rsel;
      logic          rsel_ok;
      logic [31:0]   rdata;
   } acs_state_type;

endpackage
`default_nettype wire

// *** test/acs_analog_model.sv ***
// Behavioural analog core answering the sequencer's conversion requests
`default_nettype none
module acs_analog_model (
   // Clock and reset
   input wire logic                        hclk,
   input wire logic                        hresetn,
   // Request and answer
   input wire acs_pkg::acs_analog_req_type analog_req,
   output logic [9:0]                      analog_result
);
   timeunit 1ns;
   timeprecision 100ps;

   // Channel code while converting; toggles otherwise so a stale sample never matches
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         analog_result <= 10'h155;
      end else if (analog_req.convert) begin
         analog_result <= {analog_req.channel, analog_req.channel, analog_req.channel, 1'b1};
      end else begin
         analog_result <= ~analog_result;
      end
   end
endmodule
`default_nettype wire

// *** test/acs_checker.sv ***
// Bus handshake and conversion phase checks for the converter sequencer
`default_nettype none
module acs_checker (
   // Clock and reset
   input wire logic                        hclk,
   input wire logic                        hresetn,
   // Bus
   input wire logic                        hsel,
   input wire logic [1:0]                  htrans,
   input wire logic                        hwrite,
   input wire logic                        hready,
   input wire logic [31:0]                 hrdata,
   input wire logic                        hreadyout,
   input wire logic                        hresp,
   // Analog core and request line
   input wire acs_pkg::acs_analog_req_type analog_req,
   input wire logic                        converter_irq
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Read taken in this cycle
   logic rd_take;
   assign rd_take = hsel && hready && htrans[1] && !hwrite;

   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   chk_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   chk_write_zero: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("write stalled");
   chk_ready_idle: assert property (!$past(rd_take) |-> hreadyout)
      else $error("stall without read");
   chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("read data moved");
   chk_phase_excl: assert property (!(analog_req.sample && analog_req.convert))
      else $error("sample and convert together");
   chk_conv_order: assert property ($rose(analog_req.convert) |-> $past(analog_req.sample))
      else $error("convert without sampling");
   chk_samp_chan: assert property ($rose(analog_req.convert) |-> $stable(analog_req.channel))
      else $error("channel changed after sampling");
   chk_chan_steady: assert property (analog_req.convert && $past(analog_req.convert) |-> $stable(analog_req.channel))
      else $error("channel moved in conversion");

   // Main scenarios reached
   cov_read: cover property (rd_take);
   cov_conv: cover property ($rose(analog_req.convert));
   cov_irq: cover property ($rose(converter_irq));
endmodule
`default_nettype wire

// *** test/acs_top_tb.sv ***
// Self-checking bench for the converter sequencer over its register bus
`include "acs_defines.svh"
`default_nettype none
`define CHK(nm, e, a) begin \
   checked++; \
   if ((a) !== (e)) begin \
      n_errors++; \
      $display("BAD %s exp %0h got %0h", nm, e, a); \
   end \
end
module acs_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] A_RES = {14'h0, `ACS_IDX_RESULT, 2'h0};
   localparam logic [31:0] A_TRG = {14'h0, `ACS_IDX_TRIG, 2'h0};
   localparam logic [31:0] A_CTL = {14'h0, `ACS_IDX_CTRL, 2'h0};
   localparam logic [31:0] A_CLK = {14'h0, `ACS_IDX_CLOCK, 2'h0};
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ext_n, tmr, irq;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [9:0]  ares;
   acs_pkg::acs_analog_req_type areq;
   int          n_errors, checked;

   assign hready = hreadyout;
   acs_top u_acs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .external_trigger_in_n(ext_n), .timer_underflow(tmr),
      .analog_req(areq), .analog_result(ares), .converter_irq(irq));
   acs_analog_model u_acs_analog_model (.hclk(hclk), .hresetn(hresetn), .analog_req(areq), .analog_result(ares));

   // 40 MHz clock
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   // One bus transfer: hold address until ready, then data phase until ready
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [31:0] a);
      bus(1'b0, a, 32'h0, q);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] e, input string nm);
      rd(a);
      `CHK(nm, e, q)
   endtask
   // Poll a status bit; the watchdog bounds the wait
   task automatic wait_bit(input int b, input logic v);
      rd(A_CTL);
      while (q[b] !== v) rd(A_CTL);
   endtask
   task automatic ext_pulse;
      ext_n <= 1'b0;
      repeat (2) @(posedge hclk);
      ext_n <= 1'b1;
      @(posedge hclk);
   endtask
   task automatic tmr_pulse;
      tmr <= 1'b1;
      @(posedge hclk);
      tmr <= 1'b0;
      @(posedge hclk);
   endtask
   function automatic logic [9:0] code(input logic [2:0] c);
      return {c, c, c, 1'b1};
   endfunction
   task automatic wrap_up;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Hang guard, far beyond the expected several hundred cycles
   initial begin
      repeat (30000) @(posedge hclk);
      n_errors++;
      wrap_up();
   end

   initial begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, tmr} = '0;
      hsize = 3'h2;
      ext_n = 1'b1;
      n_errors = 0;
      checked = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(A_TRG, 32'h7, "trg reset");
      rdc(A_CTL, 32'h0, "ctl reset");
      rdc(A_RES, 32'h0, "res reset");
      rdc(A_TRG + 32'h4, 32'h0, "unmapped");
      // Software one-time scan 6 to 1 wrapping, right justified
      wr(A_TRG, 32'h0E00);
      wr(A_CTL, 32'h1);
      wr(A_CTL, 32'h3);
      rd(A_CTL);
      `CHK("run", 1'b1, q[1])
      `CHK("active ch", 3'h6, q[10:8])
      for (int i = 0; i < 4; i++) begin
         wait_bit(4, 1'b1);
         rdc(A_RES, {22'h0, code(3'(i + 6))}, "scan res");
         rd(A_CTL);
         `CHK("cf clear", 1'b0, q[4])
      end
      wait_bit(1, 1'b0);
      repeat (60) @(posedge hclk);
      rd(A_CTL);
      `CHK("no rescan", 1'b0, q[4])
      // Timer continuous on channel 2, left justified; other sources ignored
      wr(A_CTL, 32'h0);
      wr(A_TRG, 32'h12D7);
      wr(A_CTL, 32'h9);
      wr(A_CTL, 32'hB);
      ext_pulse();
      rd(A_CTL);
      `CHK("unselected", 1'b0, q[1])
      wr(A_CTL, 32'h9);
      tmr_pulse();
      rd(A_CTL);
      `CHK("timer run", 1'b1, q[1])
      for (int i = 0; i < 2; i++) begin
         wait_bit(4, 1'b1);
         rdc(A_RES, {16'h0, code(3'h2), 6'h0}, "left res");
      end
      repeat (120) @(posedge hclk);
      rd(A_CTL);
      `CHK("owe set", 1'b1, q[5])
      `CHK("cf again", 1'b1, q[4])
      `CHK("still run", 1'b1, q[1])
      `CHK("irq owe", 1'b1, irq)
      // Abort, flags kept, write-one clear
      wr(A_CTL, 32'h9);
      rd(A_CTL);
      `CHK("aborted", 1'b0, q[1])
      rd(A_RES);
      repeat (120) @(posedge hclk);
      rd(A_CTL);
      `CHK("no result", 1'b0, q[4])
      `CHK("owe held", 1'b1, q[5])
      wr(A_CTL, 32'h29);
      rd(A_CTL);
      `CHK("owe clear", 1'b0, q[5])
      `CHK("irq low", 1'b0, irq)
      // External one-time on channel 5; ignored while disabled
      wr(A_CTL, 32'h0);
      wr(A_TRG, 32'h2D30);
      ext_pulse();
      repeat (60) @(posedge hclk);
      rd(A_CTL);
      `CHK("disabled", 1'b0, q[4])
      wr(A_CTL, 32'h1);
      tmr_pulse();
      rd(A_CTL);
      `CHK("timer ignored", 1'b0, q[1])
      ext_pulse();
      wait_bit(4, 1'b1);
      rdc(A_RES, {22'h0, code(3'h5)}, "ext res");
      wait_bit(1, 1'b0);
      // Divider field: reset code, then reserved code kept as written
      wr(A_CTL, 32'h0);
      rdc(A_CLK, 32'h0, "clk reset");
      wr(A_CLK, 32'hF);
      rdc(A_CLK, 32'hF, "clk field");
      wrap_up();
   end
endmodule
bind acs_top acs_checker u_acs_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .analog_req(analog_req), .converter_irq(converter_irq));
`default_nettype wire
